// file: shared/event_flags_regs.vh
// Register offsets, field layouts and reset values of the event flag block
`ifndef EVENT_FLAGS_REGS_VH
`define EVENT_FLAGS_REGS_VH

// Register offsets
`define ADDR_DIE_IDENTITY       8'h00
`define ADDR_SILICON_REVISION   8'h03
`define ADDR_FABRICATION_INFO   8'h04
`define ADDR_SYSTEM_EVENT_LIVE  8'h07
`define ADDR_BUCK_FAULT_STATUS  8'h08
`define ADDR_BUCK_FAULT_MASK    8'h09
`define ADDR_BUCK_FAULT_LIVE    8'h0A
`define ADDR_BOOST_FUSE_STATUS  8'h0E
`define ADDR_BOOST_FUSE_MASK    8'h0F
`define ADDR_BOOST_FUSE_LIVE    8'h10
`define ADDR_LDO_FAULT_STATUS   8'h11
`define ADDR_LDO_FAULT_MASK     8'h12
`define ADDR_LDO_FAULT_LIVE     8'h13
`define ADDR_BACKUP_BYTE_A      8'h1C
`define ADDR_BACKUP_BYTE_B      8'h1D
`define ADDR_BACKUP_BYTE_C      8'h1E
`define ADDR_BACKUP_BYTE_D      8'h1F

// System live register bit positions
`define SYS_BUTTON_BIT          0
`define SYS_UNDERVOLT_BIT       1
`define SYS_THERMAL_LSB         2
`define SYS_THERMAL_MSB         5
`define SYS_FUSE_SUPPLY_BIT     7

// Boost and fuse register bit positions
`define BOOST_FAULT_BIT         0
`define FUSE_ERROR_BIT          7

// Implemented bits of each register
`define SYS_LIVE_BITS           8'hBF
`define BUCK_BITS               8'h7F
`define BOOST_FUSE_BITS         8'h81
`define LDO_BITS                8'h3F

// Reset values
`define STATUS_RESET            8'h00
`define BUCK_MASK_RESET         8'h7F
`define BOOST_FUSE_MASK_RESET   8'h81
`define LDO_MASK_RESET          8'h3F
`define BACKUP_RESET            8'h00
`define READ_UNMAPPED           8'h00

// Identification field positions
`define DIE_VERSION_MSB         3
`define METAL_REV_MSB           3
`define FULL_REV_LSB            4
`define RETICLE_MSB             1
`define WAFER_SITE_LSB          2

`endif

// file: rtl/event_flags.v
// Event flags, masks, live sense views, identity and backup bytes
//
// Notes on behaviour
// - Sense bit 0 shows button pin level
// - Sense bit 1 high at input undervoltage
// - Sense bits 2-5 show four thermal thresholds
// - Sense bit 7 shows fuse supply pin level
// - Seven sticky buck fault flags, write-one clears
// - Seven buck mask bits, reset to masked
// - Buck live register shows current-limit detectors
// - Boost bit 0, fuse error bit 7 sticky
// - Boost and fuse masks, reset to masked
// - Boost/fuse live register shows detector states
// - Six sticky regulator fault flags, write-one clears
// - Six regulator mask bits, reset to masked
// - Regulator live register shows current-limit states
// - Die version hard-wired in low nibble
// - Revision register holds metal and full nibbles
// - Fabrication register holds reticle and site codes
// - Four read-write backup bytes kept by coin cell
// - Backup bytes cleared only by coin-cell reset
// - Line low while any unmasked flag set
// - Flags sticky; new event survives a clear
// - Unmasking a set flag asserts the line
// - Live registers unlatched and ignore all writes
`timescale 1ns/1ps
`include "event_flags_regs.vh"

module event_flags #(
    parameter [3:0] DIE_VERSION = 4'hA, // Arbitrary value
    parameter [3:0] METAL_REV   = 4'h3, // Arbitrary value
    parameter [3:0] FULL_REV    = 4'h2, // Arbitrary value
    parameter [1:0] RETICLE     = 2'h1, // Arbitrary value
    parameter [1:0] WAFER_SITE  = 2'h2  // Arbitrary value
) (
    input  wire       clk_i,
    input  wire       nrst_i,
    input  wire       backup_cell_por_n_i,
    input  wire [7:0] reg_addr_i,
    input  wire [7:0] reg_wdata_i,
    input  wire       reg_wr_i,
    input  wire       reg_rd_i,
    output reg  [7:0] reg_rdata_o,
    output reg        reg_rvalid_o,
    input  wire       button_level_sense_i,
    input  wire       undervoltage_sense_i,
    input  wire [3:0] thermal_sense_i,
    input  wire       fuse_supply_sense_i,
    input  wire [6:0] buck_fault_live_i,
    input  wire       boost_fault_live_i,
    input  wire       fuse_error_live_i,
    input  wire [5:0] ldo_fault_live_i,
    input  wire       interrupt_request_line_n_i,
    output wire       interrupt_request_line_n_o,
    output reg        interrupt_request_line_n_oe_n_o
);

    // Two-stage synchronisers for the analog detector outputs
    reg  [7:0] sys_meta_reg;
    reg  [7:0] sys_sync_reg;
    reg  [6:0] buck_meta_reg;
    reg  [6:0] buck_sync_reg;
    reg  [7:0] bf_meta_reg;
    reg  [7:0] bf_sync_reg;
    reg  [5:0] ldo_meta_reg;
    reg  [5:0] ldo_sync_reg;

    // Previous synchronised levels, for rising-edge events
    reg  [6:0] buck_prev_reg;
    reg  [7:0] bf_prev_reg;
    reg  [5:0] ldo_prev_reg;

    // Sticky flags and masks
    reg  [7:0] buck_stat_reg;
    reg  [7:0] buck_stat_next;
    reg  [7:0] buck_mask_reg;
    reg  [7:0] bf_stat_reg;
    reg  [7:0] bf_stat_next;
    reg  [7:0] bf_mask_reg;
    reg  [7:0] ldo_stat_reg;
    reg  [7:0] ldo_stat_next;
    reg  [7:0] ldo_mask_reg;

    // Coin-cell backed bytes
    reg  [7:0] backup_a_reg;
    reg  [7:0] backup_b_reg;
    reg  [7:0] backup_c_reg;
    reg  [7:0] backup_d_reg;

    wire [7:0] sys_raw;
    wire [7:0] bf_raw;
    wire [7:0] buck_live;
    wire [7:0] bf_live;
    wire [7:0] ldo_live;
    wire [7:0] buck_rise;
    wire [7:0] bf_rise;
    wire [7:0] ldo_rise;
    wire [7:0] buck_clr;
    wire [7:0] bf_clr;
    wire [7:0] ldo_clr;
    wire       pending;
    reg  [7:0] read_mux;

    // The line only ever pulls low; its level comes from the pull-up
    assign interrupt_request_line_n_o = 1'b0;

    // Level driven on the shared line is not needed here
    wire unused_line = interrupt_request_line_n_i;

    assign sys_raw[`SYS_BUTTON_BIT]                   = button_level_sense_i;
    assign sys_raw[`SYS_UNDERVOLT_BIT]                = undervoltage_sense_i;
    assign sys_raw[`SYS_THERMAL_MSB:`SYS_THERMAL_LSB] = thermal_sense_i;
    assign sys_raw[6]                                 = 1'b0;
    assign sys_raw[`SYS_FUSE_SUPPLY_BIT]              = fuse_supply_sense_i;

    assign bf_raw = {fuse_error_live_i, 6'h00, boost_fault_live_i};

    always @(posedge clk_i) begin
        if (!nrst_i) begin
            sys_meta_reg  <= 8'h00;
            sys_sync_reg  <= 8'h00;
            buck_meta_reg <= 7'h00;
            buck_sync_reg <= 7'h00;
            bf_meta_reg   <= 8'h00;
            bf_sync_reg   <= 8'h00;
            ldo_meta_reg  <= 6'h00;
            ldo_sync_reg  <= 6'h00;
        end else begin
            sys_meta_reg  <= sys_raw;
            sys_sync_reg  <= sys_meta_reg;
            buck_meta_reg <= buck_fault_live_i;
            buck_sync_reg <= buck_meta_reg;
            bf_meta_reg   <= bf_raw;
            bf_sync_reg   <= bf_meta_reg;
            ldo_meta_reg  <= ldo_fault_live_i;
            ldo_sync_reg  <= ldo_meta_reg;
        end
    end

    // Live views, never latched, unused bits forced to zero
    assign buck_live = {1'b0, buck_sync_reg} & `BUCK_BITS;
    assign bf_live   = bf_sync_reg & `BOOST_FUSE_BITS;
    assign ldo_live  = {2'b00, ldo_sync_reg} & `LDO_BITS;

    // Detector edge history starts at zero so a fault present at reset
    // release still raises its flag
    always @(posedge clk_i) begin
        if (!nrst_i) begin
            buck_prev_reg <= 7'h00;
            bf_prev_reg   <= 8'h00;
            ldo_prev_reg  <= 6'h00;
        end else begin
            buck_prev_reg <= buck_sync_reg;
            bf_prev_reg   <= bf_sync_reg;
            ldo_prev_reg  <= ldo_sync_reg;
        end
    end

    // Faults are low-to-high events
    assign buck_rise = {1'b0, buck_sync_reg & ~buck_prev_reg};
    assign bf_rise   = bf_sync_reg & ~bf_prev_reg & `BOOST_FUSE_BITS;
    assign ldo_rise  = {2'b00, ldo_sync_reg & ~ldo_prev_reg};

    // Write-one-to-clear strobes per status register
    assign buck_clr = (reg_wr_i && reg_addr_i == `ADDR_BUCK_FAULT_STATUS)
                      ? reg_wdata_i : 8'h00;
    assign bf_clr   = (reg_wr_i && reg_addr_i == `ADDR_BOOST_FUSE_STATUS)
                      ? reg_wdata_i : 8'h00;
    assign ldo_clr  = (reg_wr_i && reg_addr_i == `ADDR_LDO_FAULT_STATUS)
                      ? reg_wdata_i : 8'h00;

    // Set wins over clear so an event during a clear is not lost
    always @* begin
        buck_stat_next = ((buck_stat_reg & ~buck_clr) | buck_rise)
                         & `BUCK_BITS;
        bf_stat_next   = ((bf_stat_reg & ~bf_clr) | bf_rise)
                         & `BOOST_FUSE_BITS;
        ldo_stat_next  = ((ldo_stat_reg & ~ldo_clr) | ldo_rise)
                         & `LDO_BITS;
    end

    always @(posedge clk_i) begin
        if (!nrst_i) begin
            buck_stat_reg <= `STATUS_RESET;
            bf_stat_reg   <= `STATUS_RESET;
            ldo_stat_reg  <= `STATUS_RESET;
        end else begin
            buck_stat_reg <= buck_stat_next;
            bf_stat_reg   <= bf_stat_next;
            ldo_stat_reg  <= ldo_stat_next;
        end
    end

    // Mask registers; unused bits stay zero whatever is written
    always @(posedge clk_i) begin
        if (!nrst_i) begin
            buck_mask_reg <= `BUCK_MASK_RESET;
            bf_mask_reg   <= `BOOST_FUSE_MASK_RESET;
            ldo_mask_reg  <= `LDO_MASK_RESET;
        end else if (reg_wr_i) begin
            if (reg_addr_i == `ADDR_BUCK_FAULT_MASK) begin
                buck_mask_reg <= reg_wdata_i & `BUCK_BITS;
            end else if (reg_addr_i == `ADDR_BOOST_FUSE_MASK) begin
                bf_mask_reg <= reg_wdata_i & `BOOST_FUSE_BITS;
            end else if (reg_addr_i == `ADDR_LDO_FAULT_MASK) begin
                ldo_mask_reg <= reg_wdata_i & `LDO_BITS;
            end
        end
    end

    // Backup bytes answer only to the coin-cell reset, never to nrst_i
    always @(posedge clk_i) begin
        if (!backup_cell_por_n_i) begin
            backup_a_reg <= `BACKUP_RESET;
            backup_b_reg <= `BACKUP_RESET;
            backup_c_reg <= `BACKUP_RESET;
            backup_d_reg <= `BACKUP_RESET;
        end else if (reg_wr_i) begin
            if (reg_addr_i == `ADDR_BACKUP_BYTE_A) begin
                backup_a_reg <= reg_wdata_i;
            end else if (reg_addr_i == `ADDR_BACKUP_BYTE_B) begin
                backup_b_reg <= reg_wdata_i;
            end else if (reg_addr_i == `ADDR_BACKUP_BYTE_C) begin
                backup_c_reg <= reg_wdata_i;
            end else if (reg_addr_i == `ADDR_BACKUP_BYTE_D) begin
                backup_d_reg <= reg_wdata_i;
            end
        end
    end

    // Masked flags remain visible to polling; only the line is gated
    assign pending = |(buck_stat_reg & ~buck_mask_reg)
                   | |(bf_stat_reg & ~bf_mask_reg)
                   | |(ldo_stat_reg & ~ldo_mask_reg);

    // Enable is low while pulling the line low
    always @(posedge clk_i) begin
        if (!nrst_i) begin
            interrupt_request_line_n_oe_n_o <= 1'b1;
        end else begin
            interrupt_request_line_n_oe_n_o <= ~pending;
        end
    end

    // Read decode; reserved addresses read zero
    always @* begin
        if (reg_addr_i == `ADDR_DIE_IDENTITY) begin
            read_mux = {4'h0, DIE_VERSION};
        end else if (reg_addr_i == `ADDR_SILICON_REVISION) begin
            read_mux = {FULL_REV, METAL_REV};
        end else if (reg_addr_i == `ADDR_FABRICATION_INFO) begin
            read_mux = {4'h0, WAFER_SITE, RETICLE};
        end else if (reg_addr_i == `ADDR_SYSTEM_EVENT_LIVE) begin
            read_mux = sys_sync_reg & `SYS_LIVE_BITS;
        end else if (reg_addr_i == `ADDR_BUCK_FAULT_STATUS) begin
            read_mux = buck_stat_reg;
        end else if (reg_addr_i == `ADDR_BUCK_FAULT_MASK) begin
            read_mux = buck_mask_reg;
        end else if (reg_addr_i == `ADDR_BUCK_FAULT_LIVE) begin
            read_mux = buck_live;
        end else if (reg_addr_i == `ADDR_BOOST_FUSE_STATUS) begin
            read_mux = bf_stat_reg;
        end else if (reg_addr_i == `ADDR_BOOST_FUSE_MASK) begin
            read_mux = bf_mask_reg;
        end else if (reg_addr_i == `ADDR_BOOST_FUSE_LIVE) begin
            read_mux = bf_live;
        end else if (reg_addr_i == `ADDR_LDO_FAULT_STATUS) begin
            read_mux = ldo_stat_reg;
        end else if (reg_addr_i == `ADDR_LDO_FAULT_MASK) begin
            read_mux = ldo_mask_reg;
        end else if (reg_addr_i == `ADDR_LDO_FAULT_LIVE) begin
            read_mux = ldo_live;
        end else if (reg_addr_i == `ADDR_BACKUP_BYTE_A) begin
            read_mux = backup_a_reg;
        end else if (reg_addr_i == `ADDR_BACKUP_BYTE_B) begin
            read_mux = backup_b_reg;
        end else if (reg_addr_i == `ADDR_BACKUP_BYTE_C) begin
            read_mux = backup_c_reg;
        end else if (reg_addr_i == `ADDR_BACKUP_BYTE_D) begin
            read_mux = backup_d_reg;
        end else begin
            read_mux = `READ_UNMAPPED;
        end
    end

    // Read data is captured in the cycle of the strobe and held
    always @(posedge clk_i) begin
        if (!nrst_i) begin
            reg_rdata_o  <= 8'h00;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) begin
                reg_rdata_o <= read_mux;
            end
        end
    end

endmodule

// file: testbench/event_flags_sva.sv
// Port assertions of the event flag block
`timescale 1ns/1ps
module event_flags_sva (
    input wire       clk_i,
    input wire       nrst_i,
    input wire [7:0] reg_addr_i,
    input wire       reg_rd_i,
    input wire [7:0] reg_rdata_o,
    input wire       reg_rvalid_o,
    input wire       interrupt_request_line_n_o,
    input wire       interrupt_request_line_n_oe_n_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);
    chk_read_answer_due: assert property (
        reg_rd_i |=> reg_rvalid_o) else $error("read not answered");
    chk_answer_has_cause: assert property (
        reg_rvalid_o |-> $past(reg_rd_i)) else $error("stray valid");
    chk_rdata_held: assert property (
        !reg_rd_i |=> $stable(reg_rdata_o)) else $error("data moved");
    chk_id_upper_zero: assert property (
        reg_rd_i && reg_addr_i == 8'h00 |=> reg_rdata_o[7:4] == 4'h0)
        else $error("id upper nibble set");
    chk_fab_upper_zero: assert property (
        reg_rd_i && reg_addr_i == 8'h04 |=> reg_rdata_o[7:4] == 4'h0)
        else $error("fab upper nibble set");
    chk_buck_top_zero: assert property (
        reg_rd_i && reg_addr_i >= 8'h08 && reg_addr_i <= 8'h0A
        |=> !reg_rdata_o[7]) else $error("buck bit 7 set");
    chk_boost_gap_zero: assert property (
        reg_rd_i && reg_addr_i >= 8'h0E && reg_addr_i <= 8'h10
        |=> reg_rdata_o[6:1] == 6'h00) else $error("boost gap set");
    chk_ldo_top_zero: assert property (
        reg_rd_i && reg_addr_i >= 8'h11 && reg_addr_i <= 8'h13
        |=> reg_rdata_o[7:6] == 2'h0) else $error("ldo top bits set");
    chk_unmapped_zero: assert property (
        reg_rd_i && reg_addr_i == 8'h20 |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    chk_line_only_low: assert property (
        interrupt_request_line_n_o == 1'b0) else $error("line driven high");
    chk_reset_release: assert property (
        $rose(nrst_i) |-> interrupt_request_line_n_oe_n_o && !reg_rvalid_o)
        else $error("not idle after reset");
endmodule
bind event_flags event_flags_sva u_sva (.clk_i, .nrst_i, .reg_addr_i,
    .reg_rd_i, .reg_rdata_o, .reg_rvalid_o, .interrupt_request_line_n_o,
    .interrupt_request_line_n_oe_n_o);

// file: testbench/host_model.sv
// Host side of the register port: single byte reads and writes
`timescale 1ns/1ps
module host_model (
    input  wire       clk_i,
    output reg  [7:0] addr_o,
    output reg  [7:0] wdata_o,
    output reg        wr_o,
    output reg        rd_o,
    input  wire [7:0] rdata_i,
    input  wire       rvalid_i
);
    initial begin
        addr_o = 8'h00;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    // Idle address is inverted after each access, and data after each write, so stale values never pass
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge clk_i);
            addr_o <= a;
            wdata_o <= d;
            wr_o <= 1'b1;
            @(posedge clk_i);
            wr_o <= 1'b0;
            addr_o <= ~a;
            wdata_o <= ~d;
        end
    endtask
    task rd(input [7:0] a, output [7:0] d, output v);
        begin
            @(posedge clk_i);
            addr_o <= a;
            rd_o <= 1'b1;
            @(posedge clk_i);
            rd_o <= 1'b0;
            addr_o <= ~a;
            #1;
            d = rdata_i;
            v = rvalid_i;
        end
    endtask
endmodule

// file: testbench/event_flags_test.sv
// Self-checking bench of the event flag block
`timescale 1ns/1ps
`define CHK(g, e) begin \
    checked = checked + 1; \
    if ((g) !== (e)) begin \
        n_mismatch = n_mismatch + 1; \
        $display("FAIL t=%0t got=%h exp=%h", $time, g, e); \
    end \
end
module event_flags_test;
    localparam [3:0] DV = 4'h5; // Arbitrary value
    localparam [3:0] MR = 4'h6; // Arbitrary value
    localparam [3:0] FR = 4'h9; // Arbitrary value
    localparam [1:0] RO = 2'h3; // Arbitrary value
    localparam [1:0] WS = 2'h1; // Arbitrary value
    reg        clk_i;
    reg        nrst_i;
    reg        coin_n;
    reg        btn;
    reg        uv;
    reg  [3:0] therm;
    reg        fsup;
    reg  [6:0] buck;
    reg        boost;
    reg        ferr;
    reg  [5:0] ldo;
    wire [7:0] addr;
    wire [7:0] wdata;
    wire [7:0] rdata;
    wire       wr;
    wire       rd;
    wire       rvalid;
    wire       line_o;
    wire       oe_n;
    wire       line;
    integer    checked;
    integer    n_mismatch;
    // Open-drain wire with pull-up
    assign line = oe_n ? 1'b1 : line_o;
    event_flags #(.DIE_VERSION(DV), .METAL_REV(MR), .FULL_REV(FR),
        .RETICLE(RO), .WAFER_SITE(WS)) uut (.clk_i(clk_i), .nrst_i(nrst_i),
        .backup_cell_por_n_i(coin_n), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
        .button_level_sense_i(btn), .undervoltage_sense_i(uv),
        .thermal_sense_i(therm), .fuse_supply_sense_i(fsup),
        .buck_fault_live_i(buck), .boost_fault_live_i(boost),
        .fuse_error_live_i(ferr), .ldo_fault_live_i(ldo),
        .interrupt_request_line_n_i(line),
        .interrupt_request_line_n_o(line_o),
        .interrupt_request_line_n_oe_n_o(oe_n));
    host_model host (.clk_i(clk_i), .addr_o(addr), .wdata_o(wdata),
        .wr_o(wr), .rd_o(rd), .rdata_i(rdata), .rvalid_i(rvalid));
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    task rd_chk(input [7:0] a, input [7:0] e);
        reg [7:0] d;
        reg       v;
        begin
            host.rd(a, d, v);
            `CHK(v, 1'b1)
            `CHK(d, e)
        end
    endtask
    task wait_n(input integer n);
        begin
            repeat (n) @(posedge clk_i);
            #1;
        end
    endtask
    task t_defaults;
        begin
            rd_chk(8'h00, {4'h0, DV});
            rd_chk(8'h03, {FR, MR});
            rd_chk(8'h04, {4'h0, WS, RO});
            rd_chk(8'h08, 8'h00);
            rd_chk(8'h09, 8'h7F);
            rd_chk(8'h0E, 8'h00);
            rd_chk(8'h0F, 8'h81);
            rd_chk(8'h11, 8'h00);
            rd_chk(8'h12, 8'h3F);
            rd_chk(8'h1C, 8'h00);
            rd_chk(8'h20, 8'h00);
        end
    endtask
    task t_events;
        begin
            @(posedge clk_i);
            {buck, boost, ldo} <= 14'h3FFF;
            wait_n(5);
            @(posedge clk_i);
            {buck, boost, ldo} <= 14'h0000;
            wait_n(5);
            `CHK(oe_n, 1'b1)
            rd_chk(8'h08, 8'h7F);
            rd_chk(8'h0E, 8'h01);
            rd_chk(8'h11, 8'h3F);
            host.wr(8'h09, 8'hFC);
            rd_chk(8'h09, 8'h7C);
            `CHK(oe_n, 1'b0)
            host.wr(8'h08, 8'h01);
            wait_n(2);
            `CHK(oe_n, 1'b0)
            rd_chk(8'h08, 8'h7E);
            host.wr(8'h08, 8'h02);
            wait_n(2);
            `CHK(oe_n, 1'b1)
            host.wr(8'h08, 8'hFF);
            host.wr(8'h0E, 8'hFF);
            host.wr(8'h11, 8'hFF);
            rd_chk(8'h08, 8'h00);
            rd_chk(8'h0E, 8'h00);
            rd_chk(8'h11, 8'h00);
            host.wr(8'h12, 8'hFF);
            rd_chk(8'h12, 8'h3F);
            host.wr(8'h0F, 8'h7E);
            rd_chk(8'h0F, 8'h00);
            @(posedge clk_i);
            ferr <= 1'b1;
            wait_n(5);
            `CHK(oe_n, 1'b0)
            @(posedge clk_i);
            ferr <= 1'b0;
            rd_chk(8'h0E, 8'h80);
            host.wr(8'h0E, 8'h80);
            wait_n(2);
            `CHK(oe_n, 1'b1)
        end
    endtask
    // Second event on a flag lands on the very edge that clears it
    task t_clear_race;
        begin
            @(posedge clk_i);
            buck <= 7'h03;
            wait_n(5);
            @(posedge clk_i);
            buck <= 7'h00;
            wait_n(5);
            @(posedge clk_i);
            buck <= 7'h01;
            @(posedge clk_i);
            host.wr(8'h08, 8'h03);
            wait_n(2);
            `CHK(oe_n, 1'b0)
            rd_chk(8'h08, 8'h01);
            @(posedge clk_i);
            buck <= 7'h00;
            host.wr(8'h08, 8'h01);
            wait_n(2);
            `CHK(oe_n, 1'b1)
        end
    endtask
    task t_backup;
        begin
            host.wr(8'h1C, 8'h5A);
            host.wr(8'h1F, 8'hC3);
            @(posedge clk_i);
            nrst_i <= 1'b0;
            wait_n(2);
            @(posedge clk_i);
            nrst_i <= 1'b1;
            rd_chk(8'h1C, 8'h5A);
            rd_chk(8'h1F, 8'hC3);
            rd_chk(8'h09, 8'h7F);
            @(posedge clk_i);
            coin_n <= 1'b0;
            wait_n(2);
            @(posedge clk_i);
            coin_n <= 1'b1;
            rd_chk(8'h1C, 8'h00);
        end
    endtask
    task t_sense;
        begin
            @(posedge clk_i);
            {btn, uv, therm, fsup} <= 7'h6B;
            {buck, boost, ferr, ldo} <= {7'h55, 2'h2, 6'h2A};
            wait_n(4);
            rd_chk(8'h07, 8'h97);
            host.wr(8'h07, 8'h00);
            rd_chk(8'h07, 8'h97);
            rd_chk(8'h0A, 8'h55);
            rd_chk(8'h10, 8'h01);
            rd_chk(8'h13, 8'h2A);
            @(posedge clk_i);
            {btn, uv, therm, fsup} <= {1'b0, 1'b0, 4'hA, 1'b0};
            ferr <= 1'b1;
            wait_n(4);
            rd_chk(8'h07, 8'h28);
            rd_chk(8'h10, 8'h81);
        end
    endtask
    task complete_run;
        begin
            $display("Checks %0d, mismatches %0d", checked, n_mismatch);
            if (n_mismatch == 0 && checked > 0) begin
                $display("No errors found");
            end else begin
                $display("Errors were found");
            end
            $finish;
        end
    endtask
    // Whole run needs well under 600 cycles
    initial begin
        #(100 * 3000);
        n_mismatch = n_mismatch + 1;
        complete_run;
    end
    initial begin
        checked = 0;
        n_mismatch = 0;
        nrst_i = 1'b0;
        coin_n = 1'b0;
        {btn, uv, therm, fsup, boost, ferr} = 9'h000;
        buck = 7'h00;
        ldo = 6'h00;
        repeat (8) @(posedge clk_i);
        nrst_i <= 1'b1;
        coin_n <= 1'b1;
        t_defaults;
        t_events;
        t_clear_race;
        t_backup;
        t_sense;
        complete_run;
    end
endmodule
